// *** hdl/rcfe_core.v ***
`timescale 1ns/1ps
`include "rcfe_consts.vh"

// Overview of operation
// - 11-bit counter presents address, then increments
// - Call pushes return address onto stack
// - Return pops stack back into counter
// - 16-bit word latched into instruction register
// - 8-bit address field selects data byte
// - 8-bit literal feeds ALU with working register
// - Control picks literal load or memory operation
// - Decoder drives register and ALU controls
// - Deref port accesses byte named by pointer
// - Working register buffers operands and results
// - ALU updates nibble, carry, zero; sleep and watchdog bits set by instructions and events
// - Program bus 11-bit address, 16-bit data
// - Data memory 256 bytes, 8-bit buses
// - Four steps per cycle, one per clock at select 04h
// - Select 04h runs internal clock, no divide; other values divide four
// - Steps fetch, decode, execute, write back
// - Call, jump, return take two cycles
module rcfe_core (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Program memory
    output wire [`RCFE_PC_W-1:0] pm_addr,
    output wire pm_rd,
    input wire [`RCFE_IW-1:0] pm_data,
    // Register port
    input wire [`RCFE_RA_W-1:0] reg_addr,
    input wire [`RCFE_DW-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [`RCFE_DW-1:0] reg_rdata,
    // System events
    input wire wdt_expired,
    input wire wake_req,
    output wire sleeping
);

    // Step states
    localparam ST_FETCH = 4'b0001;
    localparam ST_DEC = 4'b0010;
    localparam ST_EXE = 4'b0100;
    localparam ST_WB = 4'b1000;

    reg [3:0] step_reg;
    reg [1:0] div_reg;
    reg [`RCFE_PC_W-1:0] pc_reg;
    reg [`RCFE_PC_W-1:0] pm_addr_reg;
    reg pm_rd_reg;
    reg [`RCFE_IW-1:0] ir_reg;
    reg [`RCFE_DW-1:0] w_reg;
    reg [`RCFE_DW-1:0] ptr_reg;
    reg [`RCFE_DW-1:0] res_reg;
    reg [`RCFE_DA_W-1:0] ea_reg;
    reg [`RCFE_DW-1:0] clksel_reg;
    reg [`RCFE_DW-1:0] rdata_reg;
    reg carry_reg;
    reg nibble_overflow_bit;
    reg zero_reg;
    reg sleep_entry_bit;
    reg watchdog_expiry_bit;
    reg halt_reg;
    reg flush_reg;
    reg [`RCFE_SP_W-1:0] sp_reg;
    reg [`RCFE_PC_W-1:0] stack_mem [0:`RCFE_STK_D-1];

    // Effective data address, deref port goes through the pointer
    function [`RCFE_DA_W-1:0] eff_addr;
        input [`RCFE_DA_W-1:0] adr;
        input [`RCFE_DA_W-1:0] ptr;
        begin
            eff_addr = (adr == `RCFE_DA_DEREF) ? ptr : adr;
        end
    endfunction

    // Instruction fields
    wire [4:0] op = ir_reg[`RCFE_OP_HI:`RCFE_OP_LO];
    wire dest_f = ir_reg[`RCFE_DEST_BIT];
    wire [`RCFE_DW-1:0] lit = ir_reg[`RCFE_FLD_HI:0];
    wire [`RCFE_DA_W-1:0] dadr = ir_reg[`RCFE_FLD_HI:0];
    wire [`RCFE_PC_W-1:0] target = ir_reg[`RCFE_PC_W-1:0];
    wire [`RCFE_SP_W-1:0] sp_dec = sp_reg - `RCFE_SP_ONE;

    // Step pacing from clock select
    wire [1:0] div_max = (clksel_reg == `RCFE_CLK_INT) ? `RCFE_DIV_FAST : `RCFE_DIV_SLOW;
    wire tick = (div_reg >= div_max) & ~halt_reg;

    // Status byte view
    reg [`RCFE_DW-1:0] st_byte;
    always @* begin
        st_byte = `RCFE_BYTE0;
        st_byte[`RCFE_ST_C] = carry_reg;
        st_byte[`RCFE_ST_NIB] = nibble_overflow_bit;
        st_byte[`RCFE_ST_Z] = zero_reg;
        st_byte[`RCFE_ST_SLP] = sleep_entry_bit;
        st_byte[`RCFE_ST_WDX] = watchdog_expiry_bit;
    end

    // Instruction decoder
    reg [3:0] alu_op;
    reg use_lit;
    reg fop;
    reg wr_w;
    reg wr_f;
    reg upd_c;
    reg upd_z;
    reg is_call;
    reg is_goto;
    reg is_ret;
    reg is_sleep;
    reg is_clrwdt;
    always @* begin
        alu_op = `RCFE_ALU_PASSA;
        use_lit = 1'b0;
        fop = 1'b0;
        wr_w = 1'b0;
        wr_f = 1'b0;
        upd_c = 1'b0;
        upd_z = 1'b0;
        is_call = 1'b0;
        is_goto = 1'b0;
        is_ret = 1'b0;
        is_sleep = 1'b0;
        is_clrwdt = 1'b0;
        case (op)
            `RCFE_OP_MOVLW: begin
                use_lit = 1'b1;
                wr_w = 1'b1;
            end
            `RCFE_OP_MOVWF: begin
                alu_op = `RCFE_ALU_PASSB;
                wr_f = 1'b1;
            end
            `RCFE_OP_MOVFW: begin
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_ADDWF: begin
                alu_op = `RCFE_ALU_ADD;
                fop = 1'b1;
                upd_c = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_SUBWF: begin
                alu_op = `RCFE_ALU_SUB;
                fop = 1'b1;
                upd_c = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_ANDWF: begin
                alu_op = `RCFE_ALU_AND;
                fop = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_IORWF: begin
                alu_op = `RCFE_ALU_OR;
                fop = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_XORWF: begin
                alu_op = `RCFE_ALU_XOR;
                fop = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_INCF: begin
                alu_op = `RCFE_ALU_INC;
                fop = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_DECF: begin
                alu_op = `RCFE_ALU_DEC;
                fop = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_CLRF: begin
                alu_op = `RCFE_ALU_CLR;
                wr_f = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_ADDLW: begin
                alu_op = `RCFE_ALU_ADD;
                use_lit = 1'b1;
                wr_w = 1'b1;
                upd_c = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_ANDLW: begin
                alu_op = `RCFE_ALU_AND;
                use_lit = 1'b1;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            `RCFE_OP_RET: is_ret = 1'b1;
            `RCFE_OP_SLEEP: is_sleep = 1'b1;
            `RCFE_OP_CLRWDT: is_clrwdt = 1'b1;
            `RCFE_OP_CALL: is_call = 1'b1;
            `RCFE_OP_GOTO: is_goto = 1'b1;
            default: alu_op = `RCFE_ALU_PASSA;
        endcase
        // Destination bit steers file operations
        if (fop) begin
            wr_w = ~dest_f;
            wr_f = dest_f;
        end
    end

    // Operand source: pointer, status or data memory
    wire [`RCFE_DW-1:0] dm_rdata;
    reg [`RCFE_DW-1:0] opnd;
    always @* begin
        if (dadr == `RCFE_DA_PTR) begin
            opnd = ptr_reg;
        end else if (dadr == `RCFE_DA_STATUS) begin
            opnd = st_byte;
        end else begin
            opnd = dm_rdata;
        end
    end

    // ALU with working register as second operand
    wire [`RCFE_DW-1:0] alu_res;
    wire alu_c;
    wire alu_nib;
    wire alu_z;
    rcfe_alu u_alu (
        .op(alu_op),
        .a(use_lit ? lit : opnd),
        .b(w_reg),
        .res(alu_res),
        .carry(alu_c),
        .nib(alu_nib),
        .zero(alu_z)
    );

    // Data memory, read issued in decode, written in write back
    wire wb_tick = tick & (step_reg == ST_WB);
    wire core_reg = (dadr == `RCFE_DA_PTR) | (dadr == `RCFE_DA_STATUS);
    wire dm_we = wb_tick & wr_f & ~core_reg;
    rcfe_dmem u_dmem (
        .mclk(mclk),
        .we(dm_we),
        .waddr(ea_reg),
        .wdata(res_reg),
        .raddr(eff_addr(pm_data[`RCFE_FLD_HI:0], ptr_reg)),
        .rdata(dm_rdata)
    );

    // Return address stack storage
    always @(posedge mclk) begin
        if (wb_tick && !flush_reg && is_call) begin
            stack_mem[sp_reg] <= pc_reg;
        end
    end

    // Step sequencer and core state
    always @(posedge mclk) begin
        if (srst) begin
            step_reg <= ST_FETCH;
            div_reg <= 2'h0;
            pc_reg <= `RCFE_PC_RST;
            pm_addr_reg <= `RCFE_PC_RST;
            pm_rd_reg <= 1'b0;
            ir_reg <= `RCFE_NOP;
            w_reg <= `RCFE_BYTE0;
            ptr_reg <= `RCFE_BYTE0;
            res_reg <= `RCFE_BYTE0;
            ea_reg <= `RCFE_BYTE0;
            carry_reg <= 1'b0;
            nibble_overflow_bit <= 1'b0;
            zero_reg <= 1'b0;
            sleep_entry_bit <= 1'b0;
            watchdog_expiry_bit <= 1'b0;
            halt_reg <= 1'b0;
            flush_reg <= 1'b0;
            sp_reg <= {`RCFE_SP_W{1'b0}};
        end else begin
            pm_rd_reg <= 1'b0;
            if (tick) begin
                div_reg <= 2'h0;
            end else begin
                div_reg <= div_reg + `RCFE_DIV_ONE;
            end
            if (tick) begin
                case (step_reg)
                    ST_FETCH: begin
                        step_reg <= ST_DEC;
                        if (!flush_reg) begin
                            pm_addr_reg <= pc_reg;
                            pm_rd_reg <= 1'b1;
                            pc_reg <= pc_reg + `RCFE_PC_ONE;
                        end
                    end
                    ST_DEC: begin
                        step_reg <= ST_EXE;
                        // Dummy second cycle of a jump runs as no operation
                        ir_reg <= flush_reg ? `RCFE_NOP : pm_data;
                        ea_reg <= eff_addr(pm_data[`RCFE_FLD_HI:0], ptr_reg);
                    end
                    ST_EXE: begin
                        step_reg <= ST_WB;
                        res_reg <= alu_res;
                        if (upd_c) begin
                            carry_reg <= alu_c;
                            nibble_overflow_bit <= alu_nib;
                        end
                        if (upd_z) begin
                            zero_reg <= alu_z;
                        end
                    end
                    ST_WB: begin
                        step_reg <= ST_FETCH;
                        if (wr_w) begin
                            w_reg <= res_reg;
                        end
                        if (wr_f && dadr == `RCFE_DA_PTR) begin
                            ptr_reg <= res_reg;
                        end
                        if (wr_f && dadr == `RCFE_DA_STATUS) begin
                            carry_reg <= res_reg[`RCFE_ST_C];
                            nibble_overflow_bit <= res_reg[`RCFE_ST_NIB];
                            zero_reg <= res_reg[`RCFE_ST_Z];
                        end
                        if (flush_reg) begin
                            flush_reg <= 1'b0;
                        end else if (is_call) begin
                            sp_reg <= sp_reg + `RCFE_SP_ONE;
                            pc_reg <= target;
                            flush_reg <= 1'b1;
                        end else if (is_goto) begin
                            pc_reg <= target;
                            flush_reg <= 1'b1;
                        end else if (is_ret) begin
                            sp_reg <= sp_dec;
                            pc_reg <= stack_mem[sp_dec];
                            flush_reg <= 1'b1;
                        end
                        if (is_clrwdt) begin
                            sleep_entry_bit <= 1'b0;
                            watchdog_expiry_bit <= 1'b0;
                        end
                        if (is_sleep) begin
                            sleep_entry_bit <= 1'b1;
                            watchdog_expiry_bit <= 1'b0;
                            halt_reg <= 1'b1;
                        end
                    end
                    default: step_reg <= ST_FETCH;
                endcase
            end
            // Wake from sleep on request or watchdog
            if (halt_reg && (wake_req || wdt_expired)) begin
                halt_reg <= 1'b0;
            end
            // Expiry sets after any clear so it is never lost
            if (wdt_expired) begin
                watchdog_expiry_bit <= 1'b1;
            end
        end
    end

    // Register port write
    always @(posedge mclk) begin
        if (srst) begin
            clksel_reg <= `RCFE_CLKSEL_RST;
        end else if (reg_wr && reg_addr == `RCFE_RA_CLKSEL) begin
            clksel_reg <= reg_wdata;
        end
    end

    // Register port read, data valid one cycle after strobe
    always @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= `RCFE_BYTE0;
        end else if (!reg_rd) begin
            rdata_reg <= `RCFE_BYTE0;
        end else if (reg_addr == `RCFE_RA_CLKSEL) begin
            rdata_reg <= clksel_reg;
        end else if (reg_addr == `RCFE_RA_STATUS) begin
            rdata_reg <= st_byte;
        end else if (reg_addr == `RCFE_RA_PCLO) begin
            rdata_reg <= pc_reg[`RCFE_DW-1:0];
        end else if (reg_addr == `RCFE_RA_PCHI) begin
            rdata_reg <= {{(2*`RCFE_DW-`RCFE_PC_W){1'b0}}, pc_reg[`RCFE_PC_W-1:`RCFE_DW]};
        end else if (reg_addr == `RCFE_RA_WORK) begin
            rdata_reg <= w_reg;
        end else if (reg_addr == `RCFE_RA_PTR) begin
            rdata_reg <= ptr_reg;
        end else begin
            rdata_reg <= `RCFE_BYTE0;
        end
    end

    // Outputs from flops
    assign pm_addr = pm_addr_reg;
    assign pm_rd = pm_rd_reg;
    assign reg_rdata = rdata_reg;
    assign sleeping = halt_reg;

endmodule // rcfe_core

// *** pkg/rcfe_consts.vh ***
`ifndef RCFE_CONSTS_VH
`define RCFE_CONSTS_VH

// Widths
`define RCFE_PC_W 11
`define RCFE_IW 16
`define RCFE_DW 8
`define RCFE_DA_W 8
`define RCFE_DM_DEPTH 256
`define RCFE_SP_W 3
`define RCFE_STK_D 8
`define RCFE_RA_W 3

// Reset values and increments
`define RCFE_PC_RST 11'h000
`define RCFE_PC_ONE 11'h001
`define RCFE_SP_ONE 3'h1
`define RCFE_DIV_ONE 2'h1
`define RCFE_NOP 16'h0000
`define RCFE_BYTE0 8'h00

// Clock select and step dividers
`define RCFE_CLK_INT 8'h04
`define RCFE_CLKSEL_RST 8'h04
`define RCFE_DIV_FAST 2'h0
`define RCFE_DIV_SLOW 2'h3

// Register port offsets
`define RCFE_RA_CLKSEL 3'h0
`define RCFE_RA_STATUS 3'h1
`define RCFE_RA_PCLO 3'h2
`define RCFE_RA_PCHI 3'h3
`define RCFE_RA_WORK 3'h4
`define RCFE_RA_PTR 3'h5

// Data space addresses handled by the core
`define RCFE_DA_DEREF 8'h00
`define RCFE_DA_STATUS 8'h03
`define RCFE_DA_PTR 8'h04

// Status bit positions
`define RCFE_ST_C 0
`define RCFE_ST_NIB 1
`define RCFE_ST_Z 2
`define RCFE_ST_SLP 3
`define RCFE_ST_WDX 4

// Instruction fields
`define RCFE_OP_HI 15
`define RCFE_OP_LO 11
`define RCFE_DEST_BIT 10
`define RCFE_FLD_HI 7
`define RCFE_NIB_HI 3

// Opcodes
`define RCFE_OP_NOP 5'h00
`define RCFE_OP_MOVLW 5'h01
`define RCFE_OP_MOVWF 5'h02
`define RCFE_OP_MOVFW 5'h03
`define RCFE_OP_ADDWF 5'h04
`define RCFE_OP_SUBWF 5'h05
`define RCFE_OP_ANDWF 5'h06
`define RCFE_OP_IORWF 5'h07
`define RCFE_OP_XORWF 5'h08
`define RCFE_OP_INCF 5'h09
`define RCFE_OP_DECF 5'h0a
`define RCFE_OP_CLRF 5'h0b
`define RCFE_OP_ADDLW 5'h0c
`define RCFE_OP_ANDLW 5'h0d
`define RCFE_OP_RET 5'h0e
`define RCFE_OP_SLEEP 5'h0f
`define RCFE_OP_CLRWDT 5'h10
`define RCFE_OP_CALL 5'h11
`define RCFE_OP_GOTO 5'h12

// ALU operations
`define RCFE_ALU_PASSA 4'h0
`define RCFE_ALU_PASSB 4'h1
`define RCFE_ALU_ADD 4'h2
`define RCFE_ALU_SUB 4'h3
`define RCFE_ALU_AND 4'h4
`define RCFE_ALU_OR 4'h5
`define RCFE_ALU_XOR 4'h6
`define RCFE_ALU_INC 4'h7
`define RCFE_ALU_DEC 4'h8
`define RCFE_ALU_CLR 4'h9

`endif

// *** hdl/rcfe_dmem.v ***
`timescale 1ns/1ps
`include "rcfe_consts.vh"

module rcfe_dmem (
    // Clock
    input wire mclk,
    // Write side
    input wire we,
    input wire [`RCFE_DA_W-1:0] waddr,
    input wire [`RCFE_DW-1:0] wdata,
    // Read side
    input wire [`RCFE_DA_W-1:0] raddr,
    output reg [`RCFE_DW-1:0] rdata
);

    reg [`RCFE_DW-1:0] mem [0:`RCFE_DM_DEPTH-1];

    // Byte store with registered read
    always @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule // rcfe_dmem

// *** hdl/rcfe_alu.v ***
`timescale 1ns/1ps
`include "rcfe_consts.vh"

module rcfe_alu (
    // Operation and operands
    input wire [3:0] op,
    input wire [`RCFE_DW-1:0] a,
    input wire [`RCFE_DW-1:0] b,
    // Result and flags
    output reg [`RCFE_DW-1:0] res,
    output reg carry,
    output reg nib,
    output wire zero
);

    // Full and nibble sums and differences
    wire [`RCFE_DW:0] sum = {1'b0, a} + {1'b0, b};
    wire [`RCFE_DW:0] dif = {1'b0, a} - {1'b0, b};
    wire [4:0] nsum = {1'b0, a[`RCFE_NIB_HI:0]} + {1'b0, b[`RCFE_NIB_HI:0]};
    wire [4:0] ndif = {1'b0, a[`RCFE_NIB_HI:0]} - {1'b0, b[`RCFE_NIB_HI:0]};

    // Operation select
    always @* begin
        res = a;
        carry = 1'b0;
        nib = 1'b0;
        case (op)
            `RCFE_ALU_PASSB: res = b;
            `RCFE_ALU_ADD: begin
                res = sum[`RCFE_DW-1:0];
                carry = sum[`RCFE_DW];
                nib = nsum[4];
            end
            `RCFE_ALU_SUB: begin
                res = dif[`RCFE_DW-1:0];
                carry = ~dif[`RCFE_DW]; // No borrow
                nib = ~ndif[4];
            end
            `RCFE_ALU_AND: res = a & b;
            `RCFE_ALU_OR: res = a | b;
            `RCFE_ALU_XOR: res = a ^ b;
            `RCFE_ALU_INC: res = a + `RCFE_DW'h01;
            `RCFE_ALU_DEC: res = a - `RCFE_DW'h01;
            `RCFE_ALU_CLR: res = `RCFE_BYTE0;
            default: res = a;
        endcase
    end

    assign zero = (res == `RCFE_BYTE0);

endmodule // rcfe_alu

// *** verif/rcfe_core_chk.sv ***
`timescale 1ns/1ps
`include "rcfe_consts.vh"

module rcfe_core_chk (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Program memory
    input wire [`RCFE_PC_W-1:0] pm_addr,
    input wire pm_rd,
    input wire [`RCFE_IW-1:0] pm_data,
    // Register port
    input wire [`RCFE_RA_W-1:0] reg_addr,
    input wire [`RCFE_DW-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [`RCFE_DW-1:0] reg_rdata,
    // System events
    input wire wdt_expired,
    input wire wake_req,
    input wire sleeping
);
    reg slow_reg;

    // Shadow of the pacing chosen by the clock select
    always @(posedge mclk) begin
        if (srst)
            slow_reg <= 1'b0;
        else if (reg_wr && reg_addr == `RCFE_RA_CLKSEL)
            slow_reg <= (reg_wdata != `RCFE_CLK_INT);
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_rst_out;
        $fell(srst) |-> pm_addr == `RCFE_PC_RST && !pm_rd && !sleeping
            && reg_rdata == `RCFE_BYTE0;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs not cleared by reset");

    property p_fetch_gap;
        pm_rd |=> !pm_rd [*3];
    endproperty
    a_fetch_gap: assert property (p_fetch_gap)
        else $error("fetches closer than four cycles");

    property p_addr_hold;
        pm_rd |=> $stable(pm_addr) [*3];
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("program address moved inside a cycle");

    property p_sleep_nofetch;
        sleeping |-> !pm_rd;
    endproperty
    a_sleep_nofetch: assert property (p_sleep_nofetch)
        else $error("fetch while halted");

    property p_slow_gap;
        pm_rd && slow_reg |=> !pm_rd [*8];
    endproperty
    a_slow_gap: assert property (p_slow_gap)
        else $error("slow pacing fetched too early");

    property p_sleep_bit;
        reg_rd && reg_addr == `RCFE_RA_STATUS && sleeping
            |=> reg_rdata[`RCFE_ST_SLP];
    endproperty
    a_sleep_bit: assert property (p_sleep_bit)
        else $error("sleep bit clear while halted");

    property p_wdt_bit;
        reg_rd && reg_addr == `RCFE_RA_STATUS && $past(wdt_expired)
            |=> reg_rdata[`RCFE_ST_WDX];
    endproperty
    a_wdt_bit: assert property (p_wdt_bit)
        else $error("expiry bit not set");

    property p_wake;
        sleeping && (wake_req || wdt_expired) |-> ##[1:2] !sleeping;
    endproperty
    a_wake: assert property (p_wake)
        else $error("core did not wake");
endmodule // rcfe_core_chk

// *** verif/rcfe_pmem_model.sv ***
`timescale 1ns/1ps
`include "rcfe_consts.vh"

module rcfe_pmem_model (
    // Program bus
    input wire [`RCFE_PC_W-1:0] pm_addr,
    output wire [`RCFE_IW-1:0] pm_data
);
    logic [`RCFE_IW-1:0] mem [0:2047];

    // Unwritten words read as no-op
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = `RCFE_NOP;
        end
    end

    // Combinational read of the held address
    assign pm_data = mem[pm_addr];
endmodule // rcfe_pmem_model

// *** verif/rcfe_core_tb.sv ***
`timescale 1ns/1ps
`include "rcfe_consts.vh"

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end

module rcfe_core_tb;
    reg mclk = 1'b0;
    reg srst = 1'b1;
    reg [2:0] reg_addr = 3'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg wdt_expired = 1'b0;
    reg wake_req = 1'b0;
    wire [10:0] pm_addr;
    wire pm_rd;
    wire [15:0] pm_data;
    wire [7:0] reg_rdata;
    wire sleeping;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    logic [10:0] fa[$];
    int fc[$];
    int e_a[10] = '{0, 1, 2, 3, 4, 5, 6, 16, 17, 7};
    int e_g[10] = '{0, 4, 4, 4, 4, 4, 4, 8, 4, 8};
    // subwf, xorwf, incf deref, andlw, iorwf, decf deref, andwf, clrf, iorwf, clrwdt, goto self
    logic [15:0] ops[11] = '{16'h2820, 16'h4420, 16'h4800, 16'h680c, 16'h3820, 16'h5400,
        16'h3020, 16'h5821, 16'h3821, 16'h8000, 16'h902a};

    rcfe_core i_dut (.mclk(mclk), .srst(srst), .pm_addr(pm_addr), .pm_rd(pm_rd),
        .pm_data(pm_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wdt_expired(wdt_expired), .wake_req(wake_req), .sleeping(sleeping));
    rcfe_pmem_model i_pmem (.pm_addr(pm_addr), .pm_data(pm_data));

    always #2.5 mclk = ~mclk;

    // Cycle count, fetch trace and hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (srst) begin
            fa.delete();
            fc.delete();
        end else if (pm_rd) begin
            fa.push_back(pm_addr);
            fc.push_back(cyc);
        end
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task print_verdict;
        $display("counts: mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    task wait_sleep;
        int k;
        k = 0;
        while (sleeping !== 1'b1 && k < 400) begin
            @(posedge mclk);
            #1;
            k++;
        end
        `CHK(sleeping, 1'b1)
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        i_pmem.mem[0] = 16'h0855;
        i_pmem.mem[1] = 16'h1420;
        i_pmem.mem[2] = 16'h0820;
        i_pmem.mem[3] = 16'h1404;
        i_pmem.mem[4] = 16'h1800;
        i_pmem.mem[5] = 16'h60ab;
        i_pmem.mem[6] = 16'h8810;
        i_pmem.mem[7] = 16'h7800;
        i_pmem.mem[8] = 16'h9008;
        i_pmem.mem[16] = 16'h080f;
        i_pmem.mem[17] = 16'h7000;
        repeat (14) @(posedge mclk);
        srst <= 1'b0;
        // Straight code, call, return, sleep
        wait_sleep();
        for (int i = 0; i < 10; i++) begin
            `CHK(fa[i], e_a[i])
            if (i > 0) `CHK(fc[i] - fc[i - 1], e_g[i])
        end
        rd_chk(`RCFE_RA_WORK, 8'h0f);
        rd_chk(`RCFE_RA_STATUS, 8'h0f);
        rd_chk(`RCFE_RA_PCLO, 8'h08);
        rd_chk(`RCFE_RA_PCHI, 8'h00);
        rd_chk(`RCFE_RA_PTR, 8'h20);
        rd_chk(`RCFE_RA_CLKSEL, `RCFE_CLK_INT);
        wr(`RCFE_RA_WORK, 8'haa);
        rd_chk(`RCFE_RA_WORK, 8'h0f);
        rd_chk(3'h6, 8'h00);
        n = fa.size();
        repeat (40) @(posedge mclk);
        `CHK(fa.size(), n)
        $display("test run_to_sleep done");
        // Wake into a jump loop
        @(posedge mclk);
        wake_req <= 1'b1;
        @(posedge mclk);
        wake_req <= 1'b0;
        repeat (40) @(posedge mclk);
        `CHK(fa[n], 11'h008)
        `CHK(fc[$] - fc[$ - 1], 8)
        $display("test wake done");
        // Slow pacing and back
        wr(`RCFE_RA_CLKSEL, 8'h00);
        repeat (100) @(posedge mclk);
        `CHK(fc[$] - fc[$ - 1], 32)
        rd_chk(`RCFE_RA_CLKSEL, 8'h00);
        wr(`RCFE_RA_CLKSEL, `RCFE_CLK_INT);
        repeat (30) @(posedge mclk);
        `CHK(fc[$] - fc[$ - 1], 8)
        $display("test pacing done");
        // Watchdog expiry seen in status
        @(posedge mclk);
        wdt_expired <= 1'b1;
        @(posedge mclk);
        wdt_expired <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= `RCFE_RA_STATUS;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, 8'h1f)
        $display("test watchdog done");
        // Jump from the loop into file, literal and pointer operations, then clear watchdog state
        for (int i = 0; i < 11; i++) begin
            i_pmem.mem[32 + i] = ops[i];
        end
        i_pmem.mem[8] = 16'h9020;
        repeat (80) @(posedge mclk);
        #1;
        `CHK(fa[$], 11'h02a)
        rd_chk(`RCFE_RA_WORK, 8'h12);
        rd_chk(`RCFE_RA_STATUS, 8'h01);
        $display("test ops done");
        // Reset in mid-run
        wr(`RCFE_RA_CLKSEL, 8'h00);
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd_chk(`RCFE_RA_WORK, 8'h00);
        rd_chk(`RCFE_RA_STATUS, 8'h00);
        rd_chk(`RCFE_RA_CLKSEL, `RCFE_CLKSEL_RST);
        wait_sleep();
        `CHK(fa[0], 11'h000)
        `CHK(fc[1] - fc[0], 4)
        $display("test reset done");
        print_verdict();
    end
endmodule // rcfe_core_tb

bind rcfe_core rcfe_core_chk i_chk (.mclk(mclk), .srst(srst), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_data(pm_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wdt_expired(wdt_expired), .wake_req(wake_req), .sleeping(sleeping));
